// ### core/rsi_cfg.svh
`ifndef RSI_CFG_SVH
`define RSI_CFG_SVH
// Functional notes
// RULE1 - Status holds a watchdog time-out flag and a power-down flag, both cleared by power-on.
// RULE2 - A low-voltage reset in fast or slow mode leaves both status flags as they were.
// RULE3 - A watchdog reset in fast or slow mode sets the time-out flag and keeps power-down.
// RULE4 - A watchdog reset in idle or sleep sets both the time-out and power-down flags.
// RULE5 - Power-on and both kinds of watchdog reset clear the program counter low byte.
// RULE6 - Power-on clears every interrupt enable so nothing is taken until re-enabled; por_req leaves evt_enable_reg as it was, so irq can assert at once.
// RULE7 - Power-on clears the watchdog and time base counters and the watchdog runs at once.
// RULE8 - Power-on and run-mode watchdog reset stop the counter: control 00-0 1000, count zero.
// RULE9 - Power-on and run-mode watchdog reset set port data and direction high, enables low.
// RULE10 - Power-on sets the stack pointer to the top of the hardware stack.
// RULE11 - Watchdog control: 0101 0011 on power-on, soft flag kept on run reset, idle keeps all.
// RULE12 - Interrupt, time base and clock control take their presets except in idle watchdog reset.
// RULE13 - Indirect, pointer, working and table registers are untouched by any reset cause.
// RULE14 - Idle watchdog reset keeps all but pc low, stack and flags; unused bits read zero.
// RULE15 - The soft reset flag is set by a bad enable code reset and cleared only by software; power-on also clears it.
// RULE16 - Power-on together with any other cause applies the power-on values and flags.

// Byte offsets of the APB map
`define RSI_OFS_STATUS   7'h00
`define RSI_OFS_EVT_STAT 7'h40
`define RSI_OFS_EVT_CLR  7'h44
`define RSI_OFS_EVT_EN   7'h48
`define RSI_OFS_STACK    7'h4C
`define RSI_NUM_BANKS    16
`define RSI_NUM_WORDS    20

// Flag bit positions
`define RSI_TOUT_BIT  5
`define RSI_PWDN_BIT  4
`define RSI_SOFT_BIT  2

// Per-bank tables, index 15 first: table ptr, working, memory ptr, indirect, wake-up,
// pull-up, direction, port data, clock ctl, irq ctl, time base, pc low, count, counter ctl,
// watchdog ctl, status
`define RSI_IMPL  {8'hFF,8'hFF,8'hFF,8'hFF,8'hFF,8'hFF,8'hFF,8'hFF, \
                   8'h2F,8'h37,8'h0F,8'hFF,8'hFF,8'hDF,8'hFF,8'h3F}
`define RSI_POR_V {8'h00,8'h00,8'h00,8'h00,8'h00,8'h00,8'hFF,8'hFF, \
                   8'h20,8'h00,8'h00,8'h00,8'h00,8'h08,8'h53,8'h00}
`define RSI_POR_K {8'hFF,8'hFF,8'hFF,8'hFF,8'h00,8'h00,8'h00,8'h00, \
                   8'h00,8'h00,8'h00,8'h00,8'h00,8'h00,8'h00,8'h0F}
`define RSI_NRM_V {8'h00,8'h00,8'h00,8'h00,8'h00,8'h00,8'hFF,8'hFF, \
                   8'h20,8'h00,8'h00,8'h00,8'h00,8'h08,8'h53,8'h20}
`define RSI_NRM_K {8'hFF,8'hFF,8'hFF,8'hFF,8'h00,8'h00,8'h00,8'h00, \
                   8'h00,8'h00,8'h00,8'h00,8'h00,8'h00,8'h04,8'h1F}
`define RSI_IDL_V {8'h00,8'h00,8'h00,8'h00,8'h00,8'h00,8'h00,8'h00, \
                   8'h00,8'h00,8'h00,8'h00,8'h00,8'h00,8'h00,8'h30}
`define RSI_IDL_K {8'hFF,8'hFF,8'hFF,8'hFF,8'hFF,8'hFF,8'hFF,8'hFF, \
                   8'hFF,8'hFF,8'hFF,8'h00,8'hFF,8'hFF,8'hFF,8'h0F}
// Low-voltage keeps the soft flag: only software or power-on may clear it
`define RSI_LOWV_K {8'h00,8'h00,8'h00,8'h00,8'h00,8'h00,8'h00,8'h00, \
                    8'h00,8'h00,8'h00,8'h00,8'h00,8'h00,8'h04,8'h30}
`define RSI_SFT_K {8'h00,8'h00,8'h00,8'h00,8'h00,8'h00,8'h00,8'h00, \
                   8'h00,8'h00,8'h00,8'h00,8'h00,8'h00,8'h00,8'h20}
`define RSI_WMASK {8'hFF,8'hFF,8'hFF,8'hFF,8'hFF,8'hFF,8'hFF,8'hFF, \
                   8'hFF,8'hFF,8'hFF,8'hFF,8'hFF,8'hFF,8'hFF,8'h0F}

`define RSI_WDT_ON_CODE  5'b0_1010
`define RSI_WDT_OFF_CODE 5'b1_0101
`endif

// ### core/rsi_pkg.sv
package rsi_pkg;
  typedef enum logic [1:0] {
    RSI_MODE_FAST,
    RSI_MODE_SLOW,
    RSI_MODE_IDLE,
    RSI_MODE_SLEEP
  } rsi_mode_e;

  typedef enum logic [2:0] {
    RSI_C_NONE,
    RSI_C_POR,
    RSI_C_LOWV,
    RSI_C_WNRM,
    RSI_C_WIDL,
    RSI_C_SOFT
  } rsi_cause_e;

  typedef logic [7:0] rsi_byte_t;
endpackage

// ### core/rsi_ctl_if.sv
`timescale 1ns/100ps
interface rsi_ctl_if;
  import rsi_pkg::*;
  logic       ce;
  rsi_cause_e cause;
  rsi_byte_t  wdata;
  modport drv  (output ce, output cause, output wdata);
  modport bank (input ce, input cause, input wdata);
endinterface

// ### core/rsi_bank.sv
`timescale 1ns/100ps
module rsi_bank #(
  parameter logic [7:0] IMPL  = 8'hFF,
  parameter logic [7:0] POR_V = 8'h00,
  parameter logic [7:0] POR_K = 8'h00,
  parameter logic [7:0] NRM_V = 8'h00,
  parameter logic [7:0] NRM_K = 8'h00,
  parameter logic [7:0] IDL_V = 8'h00,
  parameter logic [7:0] IDL_K = 8'hFF,
  parameter logic [7:0] LOWV_K = 8'h00,
  parameter logic [7:0] SFT_K = 8'h00,
  parameter logic [7:0] WMASK = 8'hFF
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  rsi_ctl_if.bank                ctl,
  input  wire logic              we,
  input  wire logic [7:0]        set_bits,
  output logic      [7:0]        q
);
  import rsi_pkg::*;

  logic [7:0] sel_v;
  logic [7:0] sel_k;
  logic [7:0] base;
  logic [7:0] q_next;
  logic       hit;

  // Power-on and low-voltage share presets; low-voltage only widens the keep mask
  assign sel_v = (ctl.cause == RSI_C_POR || ctl.cause == RSI_C_LOWV) ? POR_V :
                 (ctl.cause == RSI_C_WNRM || ctl.cause == RSI_C_SOFT) ? NRM_V : IDL_V;
  assign sel_k = (ctl.cause == RSI_C_POR)  ? POR_K :
                 (ctl.cause == RSI_C_LOWV) ? (POR_K | LOWV_K) :
                 (ctl.cause == RSI_C_WNRM) ? NRM_K :
                 (ctl.cause == RSI_C_SOFT) ? (NRM_K | SFT_K) : IDL_K;
  assign hit    = (ctl.cause != RSI_C_NONE);
  // A reset cause outranks a software write in the same cycle
  assign base   = hit ? ((sel_v & ~sel_k) | (q & sel_k)) :
                  we  ? ((q & ~WMASK) | (ctl.wdata & WMASK)) : q;
  assign q_next = (base | set_bits) & IMPL; // RULE14

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= POR_V & IMPL;
    end else if (ctl.ce) begin
      q <= q_next;
    end
  end
endmodule

// ### core/rsi_top.sv
`timescale 1ns/100ps
`include "rsi_cfg.svh"
module rsi_top #(
  parameter int   ADDR_W  = 12,
  parameter int   STACK_W = 3,
  parameter logic [STACK_W-1:0] SP_TOP = '0
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                clk_en,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [ADDR_W-1:0]   paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                por_req,
  input  wire logic                low_voltage_reset,
  input  wire logic                wdt_timeout,
  input  wire logic                soft_reset_req,
  input  wire rsi_pkg::rsi_mode_e  power_mode,
  output logic                     watchdog_timeout_flag,
  output logic                     powerdown_flag,
  output logic      [7:0]          program_counter_low,
  output logic      [STACK_W-1:0]  stack_ptr,
  output logic      [7:0]          interrupt_control_reg,
  output logic      [7:0]          watchdog_control_reg,
  output logic                     wdt_enable,
  output logic                     wdt_code_bad,
  output logic      [7:0]          counter_control_reg,
  output logic      [7:0]          counter_value_reg,
  output logic      [7:0]          time_base_control,
  output logic      [7:0]          system_clock_control,
  output logic      [7:0]          port_a_data,
  output logic      [7:0]          port_a_direction,
  output logic      [7:0]          port_a_pullup_enables,
  output logic      [7:0]          port_a_wakeup_enables,
  output logic                     wdt_tb_clear,
  output logic                     core_restart,
  output logic                     irq
);
  import rsi_pkg::*;

  localparam int NB = `RSI_NUM_BANKS;
  localparam logic [NB-1:0][7:0] T_IMPL  = `RSI_IMPL;
  localparam logic [NB-1:0][7:0] T_POR_V = `RSI_POR_V;
  localparam logic [NB-1:0][7:0] T_POR_K = `RSI_POR_K;
  localparam logic [NB-1:0][7:0] T_NRM_V = `RSI_NRM_V;
  localparam logic [NB-1:0][7:0] T_NRM_K = `RSI_NRM_K;
  localparam logic [NB-1:0][7:0] T_IDL_V = `RSI_IDL_V;
  localparam logic [NB-1:0][7:0] T_IDL_K = `RSI_IDL_K;
  localparam logic [NB-1:0][7:0] T_LOWV_K = `RSI_LOWV_K;
  localparam logic [NB-1:0][7:0] T_SFT_K = `RSI_SFT_K;
  localparam logic [NB-1:0][7:0] T_WMASK = `RSI_WMASK;
  localparam logic [4:0] IDX_STATUS = 5'(`RSI_OFS_STATUS >> 2);
  localparam logic [4:0] IDX_EVT_ST = 5'(`RSI_OFS_EVT_STAT >> 2);
  localparam logic [4:0] IDX_EVT_CL = 5'(`RSI_OFS_EVT_CLR >> 2);
  localparam logic [4:0] IDX_EVT_EN = 5'(`RSI_OFS_EVT_EN >> 2);
  localparam logic [4:0] IDX_STACK  = 5'(`RSI_OFS_STACK >> 2);
  localparam logic [4:0] NUM_WORDS  = 5'(`RSI_NUM_WORDS);

  rsi_ctl_if ctl ();

  rsi_cause_e       cause;
  logic             run_mode;
  logic [4:0]       idx;
  logic             in_range;
  logic             mapped;
  logic             access;
  logic             wr;
  logic [NB-1:0]    bank_we;
  logic [7:0]       bank_q [NB];
  logic [7:0]       wctl_set;
  logic [4:0]       evt_set;
  logic [4:0]       evt_status_reg;
  logic [4:0]       evt_status_next;
  logic [4:0]       evt_enable_reg;
  logic [4:0]       evt_enable_next;
  logic [4:0]       evt_clr;
  logic [STACK_W-1:0] sp_reg;
  logic [STACK_W-1:0] sp_next;
  logic             clear_reg;
  logic             clear_next;
  logic             restart_reg;
  logic             restart_next;
  logic [7:0]       rd_byte;
  logic [7:0]       rd_evt;

  // Cause resolution, power-on first so that it always wins
  assign run_mode = (power_mode == RSI_MODE_FAST) || (power_mode == RSI_MODE_SLOW);
  // Low-voltage detection is off while halted, so it is ignored outside run modes
  assign cause = por_req                    ? RSI_C_POR  : // RULE16 RULE1
                 (wdt_timeout && !run_mode) ? RSI_C_WIDL : // RULE4
                 wdt_timeout                ? RSI_C_WNRM : // RULE3
                 (low_voltage_reset && run_mode) ? RSI_C_LOWV : // RULE2
                 soft_reset_req             ? RSI_C_SOFT : RSI_C_NONE;

  assign ctl.ce    = clk_en;
  assign ctl.cause = cause;
  assign ctl.wdata = pwdata[7:0];

  // APB decode, zero wait states
  assign idx      = paddr[6:2];
  assign in_range = (paddr[ADDR_W-1:7] == '0) && (paddr[1:0] == 2'b00);
  assign mapped   = in_range && (idx < NUM_WORDS);
  assign access   = psel && penable;
  assign wr       = access && pwrite && mapped && clk_en;
  assign pready   = 1'b1;
  assign pslverr  = access && !mapped;

  // Soft flag set wins over a software clear in the same cycle
  assign wctl_set = (cause == RSI_C_SOFT) ? (8'h01 << `RSI_SOFT_BIT) : 8'h00; // RULE15

  // One bank per core register; presets come from the tables
  genvar gi;
  generate
    for (gi = 0; gi < NB; gi++) begin : g_bank
      assign bank_we[gi] = wr && (idx == 5'(gi));
      rsi_bank #(
        .IMPL  (T_IMPL[gi]),
        .POR_V (T_POR_V[gi]),
        .POR_K (T_POR_K[gi]),
        .NRM_V (T_NRM_V[gi]),
        .NRM_K (T_NRM_K[gi]),
        .IDL_V (T_IDL_V[gi]),
        .IDL_K (T_IDL_K[gi]),
        .LOWV_K (T_LOWV_K[gi]),
        .SFT_K (T_SFT_K[gi]),
        .WMASK (T_WMASK[gi])
      ) u_bank (
        .pclk     (pclk),
        .presetn  (presetn),
        .ctl      (ctl.bank),
        .we       (bank_we[gi]),
        .set_bits ((gi == 1) ? wctl_set : 8'h00),
        .q        (bank_q[gi])
      ); // RULE5 RULE6 RULE8 RULE9 RULE11 RULE12 RULE13 RULE14
    end
  endgenerate

  // Stack pointer back to the top on every reset cause
  assign sp_next = (cause == RSI_C_POR || cause == RSI_C_WNRM ||
                    cause == RSI_C_WIDL || cause == RSI_C_LOWV ||
                    cause == RSI_C_SOFT) ? SP_TOP : sp_reg; // RULE10

  // Counter clear pulse; an idle time-out leaves the counters running
  assign clear_next   = (cause == RSI_C_POR) || (cause == RSI_C_LOWV) ||
                        (cause == RSI_C_WNRM) || (cause == RSI_C_SOFT); // RULE7
  assign restart_next = (cause != RSI_C_NONE);

  // Event capture: one sticky bit per cause
  assign evt_set = {cause == RSI_C_SOFT, cause == RSI_C_WIDL, cause == RSI_C_WNRM,
                    cause == RSI_C_LOWV, cause == RSI_C_POR};
  assign evt_clr = (wr && idx == IDX_EVT_CL) ? pwdata[4:0] : 5'h00;
  assign evt_status_next = (evt_status_reg & ~evt_clr) | evt_set;
  assign evt_enable_next = (wr && idx == IDX_EVT_EN) ? pwdata[4:0] : evt_enable_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp_reg         <= SP_TOP;
      clear_reg      <= 1'b1;
      restart_reg    <= 1'b0;
      evt_status_reg <= 5'h00;
      evt_enable_reg <= 5'h00;
    end else if (clk_en) begin
      sp_reg         <= sp_next;
      clear_reg      <= clear_next;
      restart_reg    <= restart_next;
      evt_status_reg <= evt_status_next;
      evt_enable_reg <= evt_enable_next;
    end
  end

  // Read path
  assign rd_byte = (idx < 5'(NB)) ? bank_q[idx[3:0]] : 8'h00;
  assign rd_evt  = (idx == IDX_EVT_ST) ? {3'b000, evt_status_reg} :
                   (idx == IDX_EVT_EN) ? {3'b000, evt_enable_reg} :
                   (idx == IDX_STACK)  ? 8'(sp_reg) : 8'h00;
  // Write-only clear word reads zero like an unmapped one
  assign prdata  = (access && mapped && !pwrite) ?
                   {24'h00_0000, (idx < 5'(NB)) ? rd_byte : rd_evt} : 32'h0000_0000;

  // Outputs straight from flops
  assign watchdog_timeout_flag = bank_q[IDX_STATUS[3:0]][`RSI_TOUT_BIT];
  assign powerdown_flag        = bank_q[IDX_STATUS[3:0]][`RSI_PWDN_BIT];
  assign watchdog_control_reg  = bank_q[1];
  assign counter_control_reg   = bank_q[2];
  assign counter_value_reg     = bank_q[3];
  assign program_counter_low   = bank_q[4];
  assign time_base_control     = bank_q[5];
  assign interrupt_control_reg = bank_q[6];
  assign system_clock_control  = bank_q[7];
  assign port_a_data           = bank_q[8];
  assign port_a_direction      = bank_q[9];
  assign port_a_pullup_enables = bank_q[10];
  assign port_a_wakeup_enables = bank_q[11];
  assign stack_ptr             = sp_reg;
  // Watchdog runs from the power-on code; a bad code is flagged for the reset timer
  assign wdt_enable   = (bank_q[1][7:3] == `RSI_WDT_ON_CODE); // RULE7
  assign wdt_code_bad = !wdt_enable && (bank_q[1][7:3] != `RSI_WDT_OFF_CODE); // RULE15
  assign wdt_tb_clear = clear_reg;
  assign core_restart = restart_reg;
  assign irq          = |(evt_status_reg & evt_enable_reg);
endmodule

// ### dv/rsi_top_asserts.sv
`timescale 1ns/100ps
module rsi_top_asserts #(
  parameter int                 STACK_W = 3,
  parameter logic [STACK_W-1:0] SP_TOP  = '0
) (
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               clk_en,
  input wire logic               por_req,
  input wire logic               low_voltage_reset,
  input wire logic               wdt_timeout,
  input wire logic               soft_reset_req,
  input wire rsi_pkg::rsi_mode_e power_mode,
  input wire logic               watchdog_timeout_flag,
  input wire logic               powerdown_flag,
  input wire logic [7:0]         program_counter_low,
  input wire logic [STACK_W-1:0] stack_ptr,
  input wire logic [7:0]         interrupt_control_reg,
  input wire logic [7:0]         watchdog_control_reg,
  input wire logic [7:0]         counter_control_reg,
  input wire logic [7:0]         port_a_data,
  input wire logic [7:0]         system_clock_control,
  input wire logic               wdt_tb_clear,
  input wire logic               core_restart
);
  import rsi_pkg::*;
  logic run_m;
  logic wrun_w;
  logic widl_w;
  assign run_m  = power_mode inside {RSI_MODE_FAST, RSI_MODE_SLOW};
  assign wrun_w = clk_en && wdt_timeout && !por_req && run_m;
  assign widl_w = clk_en && wdt_timeout && !por_req && !run_m;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence por_s; clk_en && por_req; endsequence
  sequence restart_s; core_restart && wdt_tb_clear; endsequence
  por_flags_a: assert property (
    por_s |=> !watchdog_timeout_flag && !powerdown_flag)
    else $error("flags not cleared by power-on");
  lowv_flags_a: assert property (
    clk_en && low_voltage_reset && run_m && !por_req && !wdt_timeout
    |=> $stable(watchdog_timeout_flag) && $stable(powerdown_flag))
    else $error("flags moved on low-voltage reset");
  wdt_run_flags_a: assert property (
    wrun_w |=> watchdog_timeout_flag && $stable(powerdown_flag))
    else $error("run watchdog flags wrong");
  wdt_idle_flags_a: assert property (
    widl_w |=> watchdog_timeout_flag && powerdown_flag)
    else $error("idle watchdog flags wrong");
  pc_low_clear_a: assert property (
    clk_en && (por_req || wdt_timeout) |=> program_counter_low == 8'h00)
    else $error("pc low not cleared");
  por_presets_a: assert property (
    por_s |=> counter_control_reg == 8'h08 && port_a_data == 8'hFF
    && interrupt_control_reg == 8'h00 && watchdog_control_reg == 8'h53
    && system_clock_control == 8'h20 && stack_ptr == SP_TOP)
    else $error("power-on presets wrong");
  por_restart_a: assert property (por_s |=> restart_s)
    else $error("no counter clear after power-on");
  wdt_run_ctl_a: assert property (
    wrun_w && !soft_reset_req |=> watchdog_control_reg ==
    {5'b0_1010, $past(watchdog_control_reg[2]), 2'b11}) else $error("watchdog control wrong");
  idle_keep_a: assert property (
    widl_w |=> $stable(port_a_data) && $stable(counter_control_reg)
    && $stable(watchdog_control_reg) && stack_ptr == SP_TOP)
    else $error("idle reset lost state");
  lowv_idle_a: assert property (
    clk_en && low_voltage_reset && !run_m && !por_req && !wdt_timeout && !soft_reset_req
    |=> !core_restart && $stable(port_a_data)) else $error("low-voltage reset acted in idle");
  soft_flag_a: assert property (
    clk_en && soft_reset_req && !por_req && !wdt_timeout && !low_voltage_reset
    |=> watchdog_control_reg[2]) else $error("soft flag not set");
  lowv_soft_keep_a: assert property (
    clk_en && low_voltage_reset && run_m && !por_req && !wdt_timeout
    |=> $stable(watchdog_control_reg[2])) else $error("soft flag lost on low-voltage reset");
endmodule

bind rsi_top rsi_top_asserts #(.STACK_W(STACK_W), .SP_TOP(SP_TOP)) u_rsi_top_asserts (.*);

// ### dv/testbench.sv
`timescale 1ns/100ps
module testbench;
  import rsi_pkg::*;
  localparam logic [2:0] SPT = 3'h5;
  localparam logic [7:0] IMPL [16] = '{8'h3F, 8'hFF, 8'hDF, 8'hFF, 8'hFF, 8'h0F, 8'h37, 8'h2F,
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
  localparam logic [7:0] PV [12] = '{8'h00, 8'h53, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h20,
    8'hFF, 8'hFF, 8'h00, 8'h00};
  localparam logic [3:0] KV [6] = '{4'h8, 4'h4, 4'h2, 4'h2, 4'h1, 4'h4};
  localparam int         CS [8] = '{3, 3, 2, 2, 1, 5, 4, 0};
  localparam rsi_mode_e  MD [8] = '{RSI_MODE_IDLE, RSI_MODE_SLEEP, RSI_MODE_FAST, RSI_MODE_SLOW,
    RSI_MODE_FAST, RSI_MODE_IDLE, RSI_MODE_FAST, RSI_MODE_SLOW};
  logic        pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
  logic        por_req = 0, low_voltage_reset = 0, wdt_timeout = 0, soft_reset_req = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, seed = 32'h0000_005F, r;
  logic        pready, pslverr, watchdog_timeout_flag, powerdown_flag, wdt_enable, e;
  logic        wdt_code_bad, wdt_tb_clear, core_restart, irq;
  logic [2:0]  stack_ptr;
  logic [7:0]  program_counter_low, interrupt_control_reg, watchdog_control_reg;
  logic [7:0]  counter_control_reg, counter_value_reg, time_base_control, system_clock_control;
  logic [7:0]  port_a_data, port_a_direction, port_a_pullup_enables, port_a_wakeup_enables;
  logic [7:0]  shd [16];
  logic [4:0]  evt = '0;
  rsi_mode_e   power_mode = RSI_MODE_FAST;
  int          miscompares = 0, compares = 0, cycles = 0;

  rsi_top #(.SP_TOP(SPT)) u_rsi_top (.*);

  always #2.5 pclk = ~pclk;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Shadow update per cause: 0 por, 1 lowv, 2 wdt run, 3 wdt idle, 4 soft, 5 lowv idle
  function automatic void predict(input int c);
    logic [7:0] w;
    w = shd[1];
    if (c inside {0, 1, 2, 4}) for (int i = 1; i < 12; i++) shd[i] = PV[i];
    if (c inside {1, 2}) shd[1] = 8'h53 | (w & 8'h04);
    if (c == 4) shd[1] = 8'h57;
    if (c == 3) shd[4] = 8'h00;
    if (c == 0) shd[0] = shd[0] & 8'h0F;
    if (c == 2) shd[0] = shd[0] | 8'h20;
    if (c == 3) shd[0] = shd[0] | 8'h30;
    if (c != 5) evt[c] = 1'b1;
  endfunction

  task automatic finish_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Waits an edge first so a release is never followed by a setup in the same step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, '0);
    chk(r, x);
  endtask

  task automatic irq_is(input logic x);
    #1;
    chk(irq, x);
  endtask

  task automatic fill();
    logic [31:0] d;
    for (int i = 0; i < 16; i++) begin
      d = rnd();
      apb(1'b1, 12'(i * 4), d);
      shd[i] = (i == 0) ? (shd[0] & 8'h30) | (d[7:0] & 8'h0F) : d[7:0] & IMPL[i];
    end
  endtask

  task automatic check_all(input int n);
    for (int i = 0; i < n; i++) rdc(12'(i * 4), {24'h00_0000, shd[i]});
    rdc(12'h04C, 32'(SPT));
    chk(watchdog_timeout_flag, shd[0][5]);
    chk(powerdown_flag, shd[0][4]);
    chk(port_a_data, shd[8]);
    chk(counter_value_reg, shd[3]);
    chk(time_base_control, shd[5]);
    chk(port_a_direction, shd[9]);
    chk(port_a_pullup_enables, shd[10]);
    chk(port_a_wakeup_enables, shd[11]);
    chk(wdt_enable, shd[1][7:3] == 5'b0_1010);
    chk(wdt_code_bad, !(shd[1][7:3] inside {5'b0_1010, 5'b1_0101}));
  endtask

  task automatic fire(input logic [3:0] k, input rsi_mode_e m);
    power_mode <= m;
    {por_req, low_voltage_reset, wdt_timeout, soft_reset_req} <= k;
    @(posedge pclk);
    {por_req, low_voltage_reset, wdt_timeout, soft_reset_req} <= 4'h0;
    power_mode <= RSI_MODE_FAST;
    @(posedge pclk);
  endtask

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      finish_test();
    end
  end

  initial begin
    for (int i = 0; i < 16; i++) shd[i] = (i < 12) ? PV[i] : 8'h00;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    check_all(16);
    foreach (CS[j]) begin
      fill();
      predict(CS[j]);
      fire(KV[CS[j]], MD[j]);
      chk(core_restart, CS[j] != 5);
      chk(wdt_tb_clear, CS[j] inside {0, 1, 2, 4});
      check_all(16);
    end
    rdc(12'h040, 32'(evt));
    apb(1'b1, 12'h048, 32'h0000_0004);
    irq_is(1'b1);
    apb(1'b1, 12'h044, 32'h0000_0004);
    irq_is(1'b0);
    rdc(12'h040, 32'h0000_001B);
    apb(1'b1, 12'h048, 32'h0000_0001);
    irq_is(1'b1);
    apb(1'b1, 12'h048, 32'h0000_0000);
    irq_is(1'b0);
    apb(1'b1, 12'h044, 32'h0000_001F);
    rdc(12'h040, 32'h0000_0000);
    rdc(12'h050, 32'h0000_0000);
    chk(e, 1'b1);
    apb(1'b1, 12'h080, 32'h0000_000F);
    chk(e, 1'b1);
    rdc(12'h000, {24'h00_0000, shd[0]});
    clk_en <= 1'b0;
    apb(1'b1, 12'h020, {24'h00_0000, ~shd[8]});
    clk_en <= 1'b1;
    rdc(12'h020, {24'h00_0000, shd[8]});
    fill();
    predict(0);
    fire(4'hF, RSI_MODE_IDLE);
    chk(core_restart, 1'b1);
    check_all(16);
    finish_test();
  end
endmodule
